// File: reset_select_and_led_logic.v
// Summary of operation
// [RULE_01] - Style 0: link LED low on valid link, blinks during reception.
// [RULE_02] - Style 1: link LED low on valid link, blinks during receive or transmit.
// [RULE_03] - Style 0: duplex LED low in full duplex, blinks on collision.
// [RULE_04] - Style 1: duplex LED low in full duplex, high in half duplex.
// [RULE_05] - Level select bit sets reset-out pin active level, 1 high, 0 low.
// [RULE_06] - Full reset resets all selected functions on both paths, self-clears.
// [RULE_07] - Receive reset resets only selected receive-side functions, self-clears.
// [RULE_08] - Software uses receive reset after init only for receive error recovery.
// [RULE_09] - Transmit reset resets only selected transmit-side functions, self-clears.
// [RULE_10] - DMA select includes transfer engine in issued reset; self-clears.
// [RULE_11] - DMA with tx/full reset clears tx transfer logic, pointer, done, active.
// [RULE_12] - DMA with rx/full reset clears rx transfer logic, pointer, done.
// [RULE_13] - FIFO select resets tx buffers and threshold or rx buffers; self-clears.
// [RULE_14] - Network select includes network functions in issued reset.
// [RULE_15] - Network tx/rx resets clear their MAC, status, mode and statistics.
// [RULE_16] - Host select includes host interface, irq, countdown, transfer in full reset.
// [RULE_17] - Reset-out select makes full reset assert reset-out pin; self-clears.
// [RULE_18] - Blinking LEDs repeat 41.89ms: 5.24ms low, 36.65ms high.
// [RULE_19] - Self-clearing bits read zero once the reset sequence completes.
`timescale 1ns/1ps
`default_nettype none
`include "reset_select_regs.vh"
module reset_select_and_led_logic #(
  parameter [23:0] LED_LOW_CYC = `RSL_LED_LOW_CYC,
  parameter [23:0] LED_HIGH_CYC = `RSL_LED_HIGH_CYC,
  parameter [7:0] PULSE_CYC = `RSL_PULSE_CYC
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  // Register port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Status pins from the network side (asynchronous)
  input wire link_valid_i,
  input wire rx_active_i,
  input wire tx_active_i,
  input wire full_duplex_i,
  input wire collision_i,
  // LED and reset-out pins
  output reg link_activity_led_o,
  output reg duplex_led_o,
  output reg reset_out_pin_o,
  // Per-function reset strobes, high while the function is held in reset
  output reg tx_dma_rst_o,
  output reg rx_dma_rst_o,
  output reg tx_fifo_rst_o,
  output reg rx_fifo_rst_o,
  output reg tx_net_rst_o,
  output reg rx_net_rst_o,
  output reg host_rst_o,
  output reg eeprom_reload_o,
  output reg busy_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire link_s;
  wire rx_s;
  wire tx_s;
  wire fdx_s;
  wire col_s;
  wire blink;

  pin_sync u_sync_link (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(link_valid_i),
    .level_o(link_s)
  );
  pin_sync u_sync_rx (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(rx_active_i),
    .level_o(rx_s)
  );
  pin_sync u_sync_tx (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(tx_active_i),
    .level_o(tx_s)
  );
  pin_sync u_sync_fdx (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(full_duplex_i),
    .level_o(fdx_s)
  );
  pin_sync u_sync_col (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(collision_i),
    .level_o(col_s)
  );

  led_blinker #(
    .LOW_CYC(LED_LOW_CYC),
    .HIGH_CYC(LED_HIGH_CYC)
  ) u_blink (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .blink_o(blink) // [RULE_18]
  );

  // ****************************************
  // Configuration and control registers
  // ****************************************
  reg indicator_style_sel_q;
  reg reset_out_level_sel_q;
  reg full_q;
  reg rx_q;
  reg tx_q;
  reg dma_q;
  reg fifo_q;
  reg net_q;
  reg host_q;
  reg eeprom_q;
  reg reset_out_pin_q;
  reg [7:0] cnt_q;
  reg active_q;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == `RSL_ADDR_CTRL) && !active_q;
  wire start = wr_ctrl && (reg_wdata_i[`RSL_BIT_FULL] || reg_wdata_i[`RSL_BIT_RX] ||
                           reg_wdata_i[`RSL_BIT_TX]);

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      indicator_style_sel_q <= `RSL_RST_STYLE;
      reset_out_level_sel_q <= `RSL_RST_LEVEL;
    end else if (reg_wr_i && reg_addr_i == `RSL_ADDR_CFG) begin
      indicator_style_sel_q <= reg_wdata_i[`RSL_BIT_STYLE];
      reset_out_level_sel_q <= reg_wdata_i[`RSL_BIT_LEVEL];
    end
  end

  // Writes to the control register while a sequence runs are ignored
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      full_q <= 1'b0;
      rx_q <= 1'b0;
      tx_q <= 1'b0;
      dma_q <= 1'b0;
      fifo_q <= 1'b0;
      net_q <= 1'b0;
      host_q <= 1'b0;
      eeprom_q <= 1'b0;
      reset_out_pin_q <= 1'b0;
      cnt_q <= 8'h00;
      active_q <= 1'b0;
    end else if (start) begin
      full_q <= reg_wdata_i[`RSL_BIT_FULL];
      rx_q <= reg_wdata_i[`RSL_BIT_RX];
      tx_q <= reg_wdata_i[`RSL_BIT_TX];
      dma_q <= reg_wdata_i[`RSL_BIT_DMA];
      fifo_q <= reg_wdata_i[`RSL_BIT_FIFO];
      net_q <= reg_wdata_i[`RSL_BIT_NET];
      host_q <= reg_wdata_i[`RSL_BIT_HOST];
      eeprom_q <= reg_wdata_i[`RSL_BIT_EEPROM];
      reset_out_pin_q <= reg_wdata_i[`RSL_BIT_RESET_OUT_PIN];
      cnt_q <= PULSE_CYC;
      active_q <= 1'b1;
    end else if (active_q) begin
      if (cnt_q == 8'h01) begin
        // All self-clearing bits drop together when the sequence ends
        full_q <= 1'b0; // [RULE_06]
        rx_q <= 1'b0; // [RULE_07]
        tx_q <= 1'b0; // [RULE_09]
        dma_q <= 1'b0; // [RULE_10]
        fifo_q <= 1'b0; // [RULE_13]
        net_q <= 1'b0;
        host_q <= 1'b0; // [RULE_16]
        eeprom_q <= 1'b0;
        reset_out_pin_q <= 1'b0; // [RULE_17]
        active_q <= 1'b0; // [RULE_19]
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // ****************************************
  // Reset fan-out
  // ****************************************
  // Full reset covers both paths; rx and tx resets cover only their own path
  wire tx_path = active_q && (full_q || tx_q); // [RULE_06] [RULE_09]
  wire rx_path = active_q && (full_q || rx_q); // [RULE_06] [RULE_07]

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_dma_rst_o <= 1'b0;
      rx_dma_rst_o <= 1'b0;
      tx_fifo_rst_o <= 1'b0;
      rx_fifo_rst_o <= 1'b0;
      tx_net_rst_o <= 1'b0;
      rx_net_rst_o <= 1'b0;
      host_rst_o <= 1'b0;
      eeprom_reload_o <= 1'b0;
      busy_o <= 1'b0;
      reset_out_pin_o <= 1'b0;
    end else begin
      tx_dma_rst_o <= tx_path && dma_q; // [RULE_10] [RULE_11]
      rx_dma_rst_o <= rx_path && dma_q; // [RULE_10] [RULE_12]
      tx_fifo_rst_o <= tx_path && fifo_q; // [RULE_13]
      rx_fifo_rst_o <= rx_path && fifo_q; // [RULE_13]
      tx_net_rst_o <= tx_path && net_q; // [RULE_14] [RULE_15]
      rx_net_rst_o <= rx_path && net_q; // [RULE_14] [RULE_15]
      host_rst_o <= active_q && full_q && host_q; // [RULE_16]
      eeprom_reload_o <= active_q && full_q && eeprom_q; // [RULE_06]
      busy_o <= active_q;
      // Pin rests at the inactive level; asserts at the selected level
      if (active_q && full_q && reset_out_pin_q) begin
        reset_out_pin_o <= reset_out_level_sel_q; // [RULE_05] [RULE_17]
      end else begin
        reset_out_pin_o <= ~reset_out_level_sel_q; // [RULE_05]
      end
    end
  end

  // ****************************************
  // LED pins
  // ****************************************
  reg link_led_d;
  reg dplx_led_d;
  always @* begin
    link_led_d = 1'b1;
    dplx_led_d = 1'b1;
    if (link_s) begin
      link_led_d = 1'b0;
      if (indicator_style_sel_q) begin
        if (rx_s || tx_s) begin
          link_led_d = blink; // [RULE_02]
        end
      end else if (rx_s) begin
        link_led_d = blink; // [RULE_01]
      end
    end
    if (fdx_s) begin
      dplx_led_d = 1'b0; // [RULE_03] [RULE_04]
    end else if (indicator_style_sel_q) begin
      dplx_led_d = 1'b1; // [RULE_04]
    end else if (col_s) begin
      dplx_led_d = blink; // [RULE_03]
    end
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_activity_led_o <= 1'b1;
      duplex_led_o <= 1'b1;
    end else begin
      link_activity_led_o <= link_led_d;
      duplex_led_o <= dplx_led_d;
    end
  end

  // ****************************************
  // Read-back
  // ****************************************
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `RSL_ADDR_CTRL: begin
          reg_rdata_o <= {7'h00, reset_out_pin_q, eeprom_q, host_q, net_q, fifo_q, dma_q, tx_q, rx_q,
                          full_q, 16'h0000}; // [RULE_19]
        end
        `RSL_ADDR_CFG: begin
          reg_rdata_o <= {16'h0000, reset_out_level_sel_q, indicator_style_sel_q, 14'h0000};
        end
        `RSL_ADDR_STAT: begin
          reg_rdata_o <= {24'h000000, active_q, link_s, rx_s, tx_s, fdx_s, col_s,
                          link_activity_led_o, duplex_led_o};
        end
        default: begin
          reg_rdata_o <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// File: reset_select_regs.vh
`ifndef RESET_SELECT_REGS_VH
`define RESET_SELECT_REGS_VH

// Register offsets (word address on the plain port)
`define RSL_ADDR_CTRL 4'h0
`define RSL_ADDR_CFG 4'h1
`define RSL_ADDR_STAT 4'h2

// Control register field positions (self-clearing bits)
`define RSL_BIT_FULL 16
`define RSL_BIT_RX 17
`define RSL_BIT_TX 18
`define RSL_BIT_DMA 19
`define RSL_BIT_FIFO 20
`define RSL_BIT_NET 21
`define RSL_BIT_HOST 22
`define RSL_BIT_EEPROM 23
`define RSL_BIT_RESET_OUT_PIN 24

// Configuration register field positions
`define RSL_BIT_STYLE 14
`define RSL_BIT_LEVEL 15

// Reset values
`define RSL_RST_STYLE 1'b0
`define RSL_RST_LEVEL 1'b0

// LED blink timing, in microseconds (tenths kept exact by using 0.1 us units)
`define RSL_LED_PERIOD_US10 418900
`define RSL_LED_LOW_US10 52400
`define RSL_LED_HIGH_US10 366500
`define RSL_CLK_NS 10
// Cycles = time in 0.1 us units * 100 ns / 10 ns
`define RSL_LED_LOW_CYC (`RSL_LED_LOW_US10 * 100 / `RSL_CLK_NS)
`define RSL_LED_HIGH_CYC (`RSL_LED_HIGH_US10 * 100 / `RSL_CLK_NS)

// Length of a triggered reset pulse in cycles
`define RSL_PULSE_CYC 16

`endif

// File: pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire pin_i,
  output reg level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// File: led_blinker.v
`timescale 1ns/1ps
`default_nettype none
`include "reset_select_regs.vh"
// Free-running blink pattern: low phase then high phase
module led_blinker #(
  parameter [23:0] LOW_CYC = `RSL_LED_LOW_CYC,
  parameter [23:0] HIGH_CYC = `RSL_LED_HIGH_CYC
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  output reg blink_o
);
  reg [23:0] cnt_q;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 24'h000000;
      blink_o <= 1'b0;
    end else if (!blink_o) begin
      if (cnt_q >= LOW_CYC - 24'h000001) begin
        cnt_q <= 24'h000000;
        blink_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 24'h000001;
      end
    end else begin
      if (cnt_q >= HIGH_CYC - 24'h000001) begin
        cnt_q <= 24'h000000;
        blink_o <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 24'h000001;
      end
    end
  end
endmodule
`default_nettype wire

// File: rsl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_select_regs.vh"
module rsl_checker #(
  parameter [7:0] PULSE_CYC = 8'h10
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic link_valid_i,
  input wire logic rx_active_i,
  input wire logic tx_active_i,
  input wire logic full_duplex_i,
  input wire logic link_activity_led_o,
  input wire logic duplex_led_o,
  input wire logic reset_out_pin_o,
  input wire logic tx_dma_rst_o,
  input wire logic rx_dma_rst_o,
  input wire logic tx_fifo_rst_o,
  input wire logic rx_fifo_rst_o,
  input wire logic tx_net_rst_o,
  input wire logic rx_net_rst_o,
  input wire logic host_rst_o,
  input wire logic busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0] cnt_q;
  logic lvl_q;
  logic rdy_q;
  logic go;
  // Accepted start request on the control word
  assign go = reg_wr_i && reg_addr_i == `RSL_ADDR_CTRL && |reg_wdata_i[18:16] && !busy_o;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= busy_o ? cnt_q + 8'h01 : 8'h00;
      rdy_q <= 1'b1;
      if (reg_wr_i && reg_addr_i == `RSL_ADDR_CFG) begin
        lvl_q <= reg_wdata_i[15];
      end
    end
  end
  a_start_pulse: assert property (go |-> ##2 busy_o)
    else $error("start did not raise busy");
  a_pulse_len: assert property ($fell(busy_o) |-> cnt_q == PULSE_CYC)
    else $error("busy length wrong");
  a_fanout_busy: assert property ((tx_dma_rst_o || rx_dma_rst_o || tx_fifo_rst_o || rx_fifo_rst_o
    || tx_net_rst_o || rx_net_rst_o || host_rst_o) |-> busy_o)
    else $error("strobe outside sequence");
  a_host_full: assert property (go |-> ##2 host_rst_o ==
    ($past(reg_wdata_i[16], 2) && $past(reg_wdata_i[22], 2)))
    else $error("host strobe wrong");
  a_rx_only: assert property (go && reg_wdata_i[19:16] == 4'ha |-> ##2 rx_dma_rst_o && !tx_dma_rst_o)
    else $error("rx reset scope wrong");
  a_tx_only: assert property (go && reg_wdata_i[20:16] == 5'h14 |-> ##2 tx_fifo_rst_o && !rx_fifo_rst_o)
    else $error("tx reset scope wrong");
  a_net_excl: assert property (go && !reg_wdata_i[21] |-> ##2 !tx_net_rst_o && !rx_net_rst_o)
    else $error("network reset not excluded");
  a_reset_out_pin_act: assert property (go && reg_wdata_i[16] && reg_wdata_i[24] |-> ##2 reset_out_pin_o == lvl_q)
    else $error("reset-out not asserted");
  a_reset_out_pin_idle: assert property (rdy_q && !busy_o && lvl_q == $past(lvl_q) |-> reset_out_pin_o == !lvl_q)
    else $error("reset-out idle level wrong");
  a_duplex_full: assert property (full_duplex_i [*8] |-> !duplex_led_o)
    else $error("duplex LED not on");
  a_link_idle: assert property ((link_valid_i && !rx_active_i && !tx_active_i) [*8] |-> !link_activity_led_o)
    else $error("link LED not steady on");
  c_full: cover property (go && reg_wdata_i[16]);
  c_rx: cover property (go && reg_wdata_i[17]);
  c_blink: cover property ($fell(duplex_led_o));
endmodule
bind reset_select_and_led_logic rsl_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.*);
`default_nettype wire

// File: reset_select_and_led_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_select_regs.vh"
module reset_select_and_led_logic_tb;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic link_valid_i = 1'b0;
  logic rx_active_i = 1'b0;
  logic tx_active_i = 1'b0;
  logic full_duplex_i = 1'b0;
  logic collision_i = 1'b0;
  wire [31:0] reg_rdata_o;
  wire link_activity_led_o, duplex_led_o, reset_out_pin_o, busy_o, eeprom_reload_o;
  wire tx_dma_rst_o, rx_dma_rst_o, tx_fifo_rst_o, rx_fifo_rst_o, tx_net_rst_o, rx_net_rst_o, host_rst_o;
  wire [7:0] fan = {tx_dma_rst_o, rx_dma_rst_o, tx_fifo_rst_o, rx_fifo_rst_o,
    tx_net_rst_o, rx_net_rst_o, host_rst_o, eeprom_reload_o};
  logic lsel = 1'b0;
  logic lvl = 1'b0;
  logic [31:0] v;
  logic [31:0] tbl [5] = '{32'h01ff0000, 32'h007a0000, 32'h007c0000, 32'h00840000, 32'h00f80000};
  int errors = 0;
  int comparisons = 0;
  wire led = lsel ? duplex_led_o : link_activity_led_o;
  reset_select_and_led_logic #(.LED_LOW_CYC(24'h000005), .LED_HIGH_CYC(24'h00001e), .PULSE_CYC(8'h06)) dut (.*);
  always #5 sys_clk_i = ~sys_clk_i;
  // ****************************
  // Bus, pin and compare helpers
  // ****************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic pins(input logic [4:0] p);
    @(posedge sys_clk_i);
    {link_valid_i, rx_active_i, tx_active_i, full_duplex_i, collision_i} <= p;
    tick(8);
  endtask
  task automatic seq(input logic [31:0] w);
    logic f, r, t;
    f = w[16];
    r = w[17] | f;
    t = w[18] | f;
    wr(`RSL_ADDR_CTRL, w);
    rd(`RSL_ADDR_CTRL, v);
    chk(v, (r | t) ? (w & 32'h01ff0000) : 32'h0, "ctrl");
    chk(busy_o, r | t, "busy");
    chk(fan, (r | t) ? {t & w[19], r & w[19], t & w[20], r & w[20], t & w[21], r & w[21], f & w[22], f & w[23]}
      : 8'h00, "fanout");
    chk(reset_out_pin_o, (f & w[24]) ? lvl : !lvl, "rst_out");
    tick(8);
    chk({busy_o, fan}, 9'h000, "done");
    rd(`RSL_ADDR_CTRL, v);
    chk(v, 32'h0, "ctrl clear");
  endtask
  task automatic steady(input logic s, input logic e);
    lsel = s;
    repeat (40) begin
      tick(1);
      chk(led, e, "steady");
    end
  endtask
  task automatic blink(input logic s);
    int n;
    lsel = s;
    for (n = 0; n < 80 && led !== 1'b0; n++) tick(1);
    if (n == 80) begin
      errors++;
      results();
    end
    for (n = 0; n < 80 && led !== 1'b1; n++) tick(1);
    if (n == 80) begin
      errors++;
      results();
    end
    for (n = 0; n < 80 && led === 1'b1; n++) tick(1);
    chk(n, 30, "high");
    for (n = 0; n < 80 && led === 1'b0; n++) tick(1);
    chk(n, 5, "low");
  endtask
  task automatic results;
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #900000;
    errors++;
    results();
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd(`RSL_ADDR_CFG, v);
    chk(v, 32'h0, "cfg");
    rd(4'hf, v);
    chk(v, 32'h0, "unmapped");
    chk(reset_out_pin_o, 1'b1, "rst_out idle");
    // Receive reset is issued twice here, by the first two table entries, before the level setup
    foreach (tbl[i]) seq(tbl[i]);
    wr(`RSL_ADDR_CFG, 32'h00008000);
    lvl = 1'b1;
    tick(2);
    chk(reset_out_pin_o, 1'b0, "rst_out high level");
    seq(32'h01010000);
    pins(5'b10100);
    steady(0, 1'b0);
    pins(5'b11000);
    blink(0);
    pins(5'b00010);
    steady(1, 1'b0);
    pins(5'b00001);
    blink(1);
    wr(`RSL_ADDR_CFG, 32'h00004000);
    lvl = 1'b0;
    pins(5'b10100);
    blink(0);
    pins(5'b00001);
    steady(1, 1'b1);
    results();
  end
endmodule
`default_nettype wire
